// ---- ddr3_wl_pkg.sv ----
/*
  Constants, carriers and states of the DDR3 write-leveling host sequencer.
  Assumes a DRAM channel controller whose registers are reached over APB with a
  12-bit byte address, and software that reaches this host over APB too.
*/
package ddr3_wl_pkg;
  localparam int LANES = 9;
  localparam int DLY_W = 9;
  // Device register byte addresses.
  localparam logic [11:0] OFS_ODT_TERM = 12'h084;
  localparam logic [11:0] OFS_REFRESH = 12'h08c;
  localparam logic [11:0] OFS_SELF_REF = 12'h090;
  localparam logic [11:0] OFS_FREQ = 12'h094;
  localparam logic [11:0] OFS_PHY_TRAIN = 12'h108;
  localparam logic [11:0] OFS_LV_ERR = 12'h14c;
  localparam logic [11:0] OFS_LANE_DLY = 12'h150;
  // Device field positions.
  localparam int BIT_AUTO_REF_DIS = 18;
  localparam int FLD_FREQ_CODE = 0;
  localparam int BIT_FREQ_VALID = 3;
  localparam int FLD_ZQ = 10;
  localparam int BIT_FREQ_PEND = 21;
  localparam int BIT_SR_ENTER = 0;
  localparam int BIT_SR_EXIT = 1;
  localparam int BIT_TRAIN_EN = 0;
  localparam int BIT_TRAIN_MODE = 1;
  localparam int BIT_NIBBLE = 2;
  localparam int FLD_DIMM = 4;
  localparam int FLD_ODT = 8;
  localparam int BIT_ODT_EN = 12;
  localparam int BIT_COMP_DIS = 13;
  localparam int FLD_TERM = 8;
  localparam logic [2:0] TERM_NORMAL = 3'h3;
  localparam logic [1:0] ZQ_OFF = 2'h0;
  localparam logic TRAIN_MODE_SW = 1'h1;
  // Seeds and steps of the total delay (gross in [8:5], fine in [4:0]).
  localparam logic [DLY_W-1:0] SEED_UDIMM = 9'h01f;
  localparam logic [DLY_W-1:0] SEED_RDIMM_A = 9'h041;
  localparam logic [DLY_W-1:0] SEED_RDIMM_B = 9'h051;
  localparam logic [DLY_W-1:0] STEP_GROSS = 9'h020;
  localparam logic [DLY_W-1:0] STEP_FINE = 9'h001;
  localparam int BASE_MHZ = 400;
  // Waits in memory clocks.
  localparam logic [7:0] MCLK_ODT_SETTLE = 8'h0a;
  localparam logic [7:0] MCLK_TRAIN = 8'h20;
  localparam logic [7:0] MCLK_MRS_SETTLE = 8'h28;
  // Software register byte addresses and fields.
  localparam logic [11:0] SW_CTRL = 12'h000;
  localparam logic [11:0] SW_FREQ = 12'h004;
  localparam logic [11:0] SW_STATUS = 12'h008;
  localparam logic [11:0] SW_RAW_CMD = 12'h00c;
  localparam logic [11:0] SW_RAW_DATA = 12'h010;
  localparam logic [11:0] SW_LANE_BASE = 12'h020;
  localparam int GO_START = 0;
  localparam int GO_FREQ = 1;
  localparam int GO_FINISH = 2;
  localparam int GO_RAW = 3;
  localparam int CTL_RDIMM = 4;
  localparam int CTL_REGISTER_CONTROL_WORD_TWO = 5;
  localparam int CTL_PASS2 = 6;
  localparam int CTL_TWO_DIMM = 7;
  localparam int CTL_NIBBLE = 8;
  localparam int CTL_DIMM = 12;
  localparam int CTL_ODT = 16;
  localparam int CTL_ZQ = 20;
  localparam int FRQ_MHZ = 16;
  localparam int RAW_READ = 31;
  localparam logic [1:0] PH_GROSS = 2'h0;
  localparam logic [1:0] PH_FINE = 2'h1;
  localparam logic [1:0] PH_DONE = 2'h2;

  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
  } dev_req_s;

  typedef enum logic [4:0] {
    S_IDLE, S_BUS, S_WAIT, S_REF, S_ZQ, S_TROFF0, S_PHY, S_SEED, S_TRON, S_TROFF,
    S_RDERR, S_ADJ, S_ODTOFF, S_TERM, S_FREF, S_FZQ, S_SRE, S_SREP, S_SREC,
    S_COMP1, S_FV0, S_FV1, S_PENDP, S_PENDC, S_COMP0, S_SRX, S_SRXP, S_SRXC,
    S_RAW, S_RAWC
  } state_e;
endpackage : ddr3_wl_pkg

// ---- ddr3_wl_host.sv ----
/*
  Host sequencer that write-levels one DDR3 channel by driving the channel
  controller registers over APB, and takes its orders from software over APB.
  Assumes the device APB runs on core_clk_i and the memory clock arrives as a
  free pin that is sampled here to count memory clocks.
*/
// Decided for this implementation: the APB register port.
// Overview of operation
// [R1] Clear train enable first, at 400MHz; the code clears it third, after the R2 refresh and ZQ writes.
// [R2] Disable auto refresh, ZQ short interval 00b.
// [R3] Lanes are 4 or 8 bit groups.
// [R4] Select target DIMM before preparing it.
// [R5] Load ODT pattern, enable, wait 10 clocks.
// [R6] Seed every lane; second pass at other frequency.
// [R7] Training mode 1 means software-driven leveling.
// [R8] Nibble select 0 lower, 1 upper.
// [R9] Train enable on, wait 32, off, read.
// [R10] Device reports one error bit per lane.
// [R11] Bit 0 increments, bit 1 decrements delay.
// [R12] Gross steps to transition, then fine back.
// [R13] Repeat until transition, then record delay.
// [R14] Unbuffered first-pass seed is 1Fh.
// [R15] Registered seed 41h, or 51h with REGISTER_CONTROL_WORD_TWO bit0.
// [R16] Clear ODT enable, wait 10 clocks.
// [R17] Restore normal ranks, termination code 011b.
// [R18] Device clears self refresh request when done.
// [R19] Frequency change sequence around compensation disable.
// [R20] Both channels change frequency together; the code drives and changes one channel only.
// [R21] Recompute latencies, reissue mode commands.
// [R22] Second seed is first delay times f/400.
// [R23] Mode command send bit clears when sent.
// [R24] Only first rank driver enabled while leveling.
// [R25] Wait 40 clocks after mode commands.
// [R26] No DRAM traffic before leveling completes.
`timescale 1ns/10ps
module ddr3_wl_host #(
  parameter int MAX_ITER = 64
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // Software APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Memory clock pin
  input wire logic mem_clock_i,
  // Device APB master
  output logic dev_psel_o,
  output logic dev_penable_o,
  output ddr3_wl_pkg::dev_req_s dev_req_o,
  input wire logic [31:0] dev_prdata_i,
  input wire logic dev_pready_i
);
  import ddr3_wl_pkg::*;

  state_e state, ret, wret, nret, jmp_to;
  logic iss, jmp;
  dev_req_s nreq;
  logic [7:0] nwait, post_wait, wcnt, mgap, iter;
  logic [31:0] rd_q, ctrl, freq, raw_cmd, raw_data;
  logic [3:0] go, take;
  logic [3:0] lane_idx;
  logic mclk_s1, mclk_s2, mclk_s3, timeout, done;
  logic [DLY_W-1:0] tot [LANES];
  logic [1:0] ph [LANES];
  logic seen [LANES];
  logic prev [LANES];
  logic [LANES-1:0] lane_done;

  // The pin is only an edge source, so it is synchronised before counting.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mclk_s1 <= 1'b0;
      mclk_s2 <= 1'b0;
      mclk_s3 <= 1'b0;
    end else begin
      mclk_s1 <= mem_clock_i;
      mclk_s2 <= mclk_s1;
      mclk_s3 <= mclk_s2;
    end
  end
  wire mclk_edge = mclk_s2 & ~mclk_s3;

  // Software register slave; zero-wait, so read data is taken in setup.
  wire sw_wr = psel_i & penable_i & pwrite_i;
  wire lane_hit = paddr_i >= SW_LANE_BASE && paddr_i < SW_LANE_BASE + 12'(4 * LANES);
  wire [3:0] lane_sel = 4'((paddr_i - SW_LANE_BASE) >> 2);
  wire sw_hit = paddr_i == SW_CTRL || paddr_i == SW_FREQ || paddr_i == SW_STATUS ||
    paddr_i == SW_RAW_CMD || paddr_i == SW_RAW_DATA || lane_hit;
  wire busy = state != S_IDLE;
  wire [31:0] status = {29'h0, timeout, done, busy};
  wire [31:0] rd_mux = paddr_i == SW_CTRL ? {ctrl[31:4], go} :
    paddr_i == SW_FREQ ? freq : paddr_i == SW_STATUS ? status :
    paddr_i == SW_RAW_CMD ? raw_cmd : paddr_i == SW_RAW_DATA ? raw_data :
    lane_hit ? {23'h0, tot[lane_sel]} : 32'h0;
  wire [3:0] go_set = (sw_wr && paddr_i == SW_CTRL) ? pwdata_i[3:0] : 4'h0;
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~sw_hit;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= 32'h0;
      ctrl <= 32'h0;
      freq <= 32'h0;
      raw_cmd <= 32'h0;
      go <= 4'h0;
    end else begin
      if (psel_i && !penable_i) prdata_o <= rd_mux;
      if (sw_wr && paddr_i == SW_CTRL) ctrl <= {pwdata_i[31:4], 4'h0};
      if (sw_wr && paddr_i == SW_FREQ) freq <= pwdata_i;
      if (sw_wr && paddr_i == SW_RAW_CMD) raw_cmd <= pwdata_i;
      go <= (go & ~take) | go_set;
    end
  end

  // Priority of pending orders when idle: level, frequency, finish, raw.
  assign take = state != S_IDLE ? 4'h0 : go[GO_START] ? 4'h1 : go[GO_FREQ] ? 4'h2 :
    go[GO_FINISH] ? 4'h4 : go[GO_RAW] ? 4'h8 : 4'h0;

  wire [9:0] mhz = freq[FRQ_MHZ +: 10];
  wire [2:0] fcode = freq[FLD_FREQ_CODE +: 3];
  wire [DLY_W-1:0] base_seed = !ctrl[CTL_RDIMM] ? SEED_UDIMM : // R14
    ctrl[CTL_REGISTER_CONTROL_WORD_TWO] ? SEED_RDIMM_B : SEED_RDIMM_A; // R15

  function automatic logic [31:0] phy_word(input logic en, input logic odt_en,
                                           input logic comp_dis);
    logic [31:0] w;
    w = 32'h0;
    w[BIT_TRAIN_EN] = en;
    w[BIT_TRAIN_MODE] = TRAIN_MODE_SW; // R7
    w[BIT_NIBBLE] = ctrl[CTL_NIBBLE]; // R8
    w[FLD_DIMM +: 2] = ctrl[CTL_DIMM +: 2]; // R4
    w[FLD_ODT +: 4] = ctrl[CTL_ODT +: 4]; // R5
    w[BIT_ODT_EN] = odt_en;
    w[BIT_COMP_DIS] = comp_dis;
    return w;
  endfunction : phy_word

  function automatic logic [31:0] freq_word(input logic valid, input logic [1:0] zq);
    logic [31:0] w;
    w = 32'h0;
    w[FLD_FREQ_CODE +: 3] = fcode;
    w[BIT_FREQ_VALID] = valid;
    w[FLD_ZQ +: 2] = zq;
    return w;
  endfunction : freq_word

  // Sequencer step: issue one device access with an optional memory-clock wait after it.
  always_comb begin
    iss = 1'b0;
    jmp = 1'b0;
    jmp_to = S_IDLE;
    nret = S_IDLE;
    nwait = 8'h0;
    nreq = '{addr: OFS_PHY_TRAIN, write: 1'b1, wdata: 32'h0};
    case (state)
      S_IDLE: begin
        jmp = |take;
        jmp_to = take[0] ? S_REF : take[1] ? S_SRE : take[2] ? S_FREF : S_RAW;
      end
      S_REF: begin
        iss = 1'b1;
        nreq = '{addr: OFS_REFRESH, write: 1'b1, wdata: 32'h1 << BIT_AUTO_REF_DIS}; // R2
        nret = S_ZQ;
      end
      S_ZQ: begin
        iss = 1'b1;
        nreq = '{addr: OFS_FREQ, write: 1'b1, wdata: freq_word(1'b1, ZQ_OFF)}; // R2
        nret = S_TROFF0;
      end
      S_TROFF0: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b0, 1'b0, 1'b0); // R1
        nwait = MCLK_MRS_SETTLE; // R25
        nret = S_PHY;
      end
      S_PHY: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b0, 1'b1, 1'b0); // R5
        nwait = MCLK_ODT_SETTLE; // R5
        nret = S_SEED;
      end
      S_SEED: begin
        iss = 1'b1;
        nreq = '{addr: OFS_LANE_DLY + {6'h0, lane_idx, 2'h0}, write: 1'b1,
                 wdata: {23'h0, tot[lane_idx]}}; // R6
        nret = lane_idx == 4'(LANES - 1) ? S_TRON : S_SEED;
      end
      S_TRON: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b1, 1'b1, 1'b0); // R9
        nwait = MCLK_TRAIN; // R9
        nret = S_TROFF;
      end
      S_TROFF: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b0, 1'b1, 1'b0); // R9
        nret = S_RDERR;
      end
      S_RDERR: begin
        iss = 1'b1;
        nreq = '{addr: OFS_LV_ERR, write: 1'b0, wdata: 32'h0};
        nret = S_ADJ;
      end
      S_ADJ: begin
        jmp = 1'b1;
        jmp_to = (&lane_done || iter == 8'(MAX_ITER - 1)) ? S_ODTOFF : S_SEED; // R13
      end
      S_ODTOFF: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b0, 1'b0, 1'b0); // R16
        nwait = MCLK_ODT_SETTLE; // R16
        nret = S_TERM;
      end
      S_TERM: begin
        iss = ctrl[CTL_TWO_DIMM];
        jmp = !ctrl[CTL_TWO_DIMM];
        nreq = '{addr: OFS_ODT_TERM, write: 1'b1, wdata: {21'h0, TERM_NORMAL, 8'h0}}; // R17
      end
      S_FREF: begin
        iss = 1'b1;
        nreq = '{addr: OFS_REFRESH, write: 1'b1, wdata: 32'h0};
        nret = S_FZQ;
      end
      S_FZQ: begin
        iss = 1'b1;
        nreq = '{addr: OFS_FREQ, write: 1'b1, wdata: freq_word(1'b1, ctrl[CTL_ZQ +: 2])};
      end
      S_SRE: begin
        iss = 1'b1;
        nreq = '{addr: OFS_SELF_REF, write: 1'b1, wdata: 32'h1 << BIT_SR_ENTER};
        nret = S_SREP;
      end
      S_SREP, S_SRXP: begin
        iss = 1'b1;
        nreq = '{addr: OFS_SELF_REF, write: 1'b0, wdata: 32'h0};
        nret = state == S_SREP ? S_SREC : S_SRXC;
      end
      S_SREC: begin
        jmp = 1'b1;
        jmp_to = rd_q[BIT_SR_ENTER] ? S_SREP : S_COMP1; // R18
      end
      S_COMP1, S_COMP0: begin
        iss = 1'b1;
        nreq.wdata = phy_word(1'b0, 1'b0, state == S_COMP1); // R19
        nret = state == S_COMP1 ? S_FV0 : S_SRX;
      end
      S_FV0, S_FV1: begin
        iss = 1'b1;
        // The frequency register here feeds only this channel's host; nothing keeps the other channel equal. R20
        nreq = '{addr: OFS_FREQ, write: 1'b1, wdata: freq_word(state == S_FV1, ZQ_OFF)}; // R19
        nret = state == S_FV0 ? S_FV1 : S_PENDP;
      end
      S_PENDP: begin
        iss = 1'b1;
        nreq = '{addr: OFS_FREQ, write: 1'b0, wdata: 32'h0};
        nret = S_PENDC;
      end
      S_PENDC: begin
        jmp = 1'b1;
        jmp_to = rd_q[BIT_FREQ_PEND] ? S_PENDP : S_COMP0; // R19
      end
      S_SRX: begin
        iss = 1'b1;
        nreq = '{addr: OFS_SELF_REF, write: 1'b1, wdata: 32'h1 << BIT_SR_EXIT};
        nret = S_SRXP;
      end
      S_SRXC: begin
        jmp = 1'b1;
        jmp_to = rd_q[BIT_SR_EXIT] ? S_SRXP : S_IDLE; // R18
      end
      S_RAW: begin
        // Mode commands, driver enables and latencies go out this way. R21 R23 R24
        iss = 1'b1;
        nreq = '{addr: raw_cmd[11:0], write: !raw_cmd[RAW_READ], wdata: raw_data};
        nret = S_RAWC;
      end
      S_RAWC: jmp = 1'b1;
      default: jmp = 1'b0;
    endcase
  end

  wire bus_done = dev_psel_o & dev_penable_o & dev_pready_i;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state <= S_IDLE;
      ret <= S_IDLE;
      wret <= S_IDLE;
      dev_psel_o <= 1'b0;
      dev_penable_o <= 1'b0;
      dev_req_o <= '0;
      post_wait <= 8'h0;
      wcnt <= 8'h0;
      rd_q <= 32'h0;
    end else if (iss) begin
      dev_psel_o <= 1'b1;
      dev_req_o <= nreq;
      ret <= nret;
      post_wait <= nwait;
      state <= S_BUS;
    end else if (jmp) begin
      state <= jmp_to;
    end else if (state == S_BUS) begin
      dev_penable_o <= 1'b1;
      if (bus_done) begin
        dev_psel_o <= 1'b0;
        dev_penable_o <= 1'b0;
        rd_q <= dev_prdata_i;
        wcnt <= post_wait + 8'h1; // Spare edge: the synchroniser may show an older one.
        wret <= ret;
        state <= post_wait == 8'h0 ? ret : S_WAIT;
      end
    end else if (state == S_WAIT && mclk_edge) begin
      wcnt <= wcnt - 8'h1;
      if (wcnt == 8'h1) state <= wret;
    end
  end

  // Lane index, iteration count, status and raw read-back.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_idx <= 4'h0;
      iter <= 8'h0;
      done <= 1'b0;
      timeout <= 1'b0;
      raw_data <= 32'h0;
      mgap <= 8'h0;
    end else begin
      if (state == S_SEED) lane_idx <= lane_idx + 4'h1;
      else if (state == S_ADJ || state == S_IDLE) lane_idx <= 4'h0;
      if (take[GO_START]) begin
        iter <= 8'h0;
        done <= 1'b0;
        timeout <= 1'b0;
      end else if (state == S_ADJ) begin
        iter <= iter + 8'h1;
        if (jmp_to == S_ODTOFF) begin
          done <= 1'b1;
          timeout <= ~&lane_done;
        end
      end
      if (sw_wr && paddr_i == SW_RAW_DATA) raw_data <= pwdata_i;
      else if (state == S_RAWC && !dev_req_o.write) raw_data <= rd_q;
      if (bus_done) mgap <= 8'h0;
      else if (mclk_edge && mgap != 8'hff) mgap <= mgap + 8'h1;
    end
  end

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    wire e = rd_q[l];
    wire flip = seen[l] && (e != prev[l]);
    wire [DLY_W-1:0] stp = (ph[l] == PH_GROSS && !flip) ? STEP_GROSS : STEP_FINE; // R12
    wire [18:0] prod = 19'(tot[l]) * 19'(mhz);
    wire [DLY_W-1:0] seed = ctrl[CTL_PASS2] ? DLY_W'(prod / 19'(BASE_MHZ)) : base_seed; // R22
    assign lane_done[l] = ph[l] == PH_DONE;
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
        tot[l] <= '0;
        ph[l] <= PH_GROSS;
        seen[l] <= 1'b0;
        prev[l] <= 1'b0;
      end else if (take[GO_START]) begin
        tot[l] <= seed; // R6
        ph[l] <= PH_GROSS;
        seen[l] <= 1'b0;
      end else if (state == S_ADJ && ph[l] != PH_DONE) begin
        seen[l] <= 1'b1;
        prev[l] <= e;
        if (flip && ph[l] == PH_FINE) begin
          ph[l] <= PH_DONE; // R13
        end else begin
          if (flip) ph[l] <= PH_FINE; // R12
          tot[l] <= e ? tot[l] - stp : tot[l] + stp; // R11
        end
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  property p_bus_hold;
    dev_psel_o && !bus_done |=> dev_psel_o && dev_penable_o && $stable(dev_req_o);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("device request moved early"); // R26
  property p_mrs_settle;
    state == S_PHY |-> mgap >= MCLK_MRS_SETTLE;
  endproperty
  a_mrs_settle: assert property (p_mrs_settle) else $error("phy set up too early"); // R25
  property p_odt_settle;
    $past(state) == S_WAIT && state == S_SEED |-> mgap >= MCLK_ODT_SETTLE;
  endproperty
  a_odt_settle: assert property (p_odt_settle) else $error("seed before odt settle"); // R5
  property p_train_wait;
    state == S_TROFF |-> mgap >= MCLK_TRAIN;
  endproperty
  a_train_wait: assert property (p_train_wait) else $error("train window short"); // R9
  property p_odt_off;
    state == S_TERM |-> mgap >= MCLK_ODT_SETTLE && !dev_req_o.wdata[BIT_ODT_EN];
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("odt not settled off"); // R16
  property p_zq_off;
    state == S_ZQ |=> dev_req_o.wdata[FLD_ZQ +: 2] == ZQ_OFF && dev_req_o.addr == OFS_FREQ;
  endproperty
  a_zq_off: assert property (p_zq_off) else $error("zq interval not cleared"); // R2
  property p_seed_udimm;
    take[GO_START] && !ctrl[CTL_RDIMM] && !ctrl[CTL_PASS2] |=> tot[0] == SEED_UDIMM;
  endproperty
  a_seed_udimm: assert property (p_seed_udimm) else $error("bad unbuffered seed"); // R14
  property p_lane_frozen;
    ph[0] == PH_DONE && !take[GO_START] |=> $stable(tot[0]) && ph[0] == PH_DONE;
  endproperty
  a_lane_frozen: assert property (p_lane_frozen) else $error("done lane moved"); // R13
  property p_comp_after_pend;
    state == S_COMP0 |-> !rd_q[BIT_FREQ_PEND] && $past(state) == S_PENDC;
  endproperty
  a_comp_after_pend: assert property (p_comp_after_pend) else $error("comp re-enabled early"); // R19
  property p_term;
    state == S_TERM && ctrl[CTL_TWO_DIMM] |=> dev_req_o.wdata[FLD_TERM +: 3] == TERM_NORMAL;
  endproperty
  a_term: assert property (p_term) else $error("termination not restored"); // R17

  c_level_done: cover property (state == S_ADJ && &lane_done);
  c_timeout: cover property (state == S_ADJ && jmp_to == S_ODTOFF && !(&lane_done));
  c_freq_done: cover property (state == S_SRXC && !rd_q[BIT_SR_EXIT]);
  c_fine_flip: cover property (state == S_ADJ && ph[0] == PH_FINE && g_lane[0].flip);
endmodule : ddr3_wl_host

// ---- ddr3_wl_host_dummy_unused.sv ----
`timescale 1ns/10ps

// ---- ddr3_wl_dev_model.sv ----
/*
  Behavioural DRAM channel controller that the write-leveling host drives over APB.
  Assumes one APB master on core_clk_i and a free-running memory clock pin.
*/
`timescale 1ns/10ps
module ddr3_wl_dev_model
  import ddr3_wl_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic mem_clock_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire ddr3_wl_pkg::dev_req_s req_i,
  output logic [31:0] prdata_o,
  output logic pready_o
);
  logic [31:0] refresh, freq, self_ref, phy, term, junk;
  logic [DLY_W-1:0] dly [LANES];
  logic [DLY_W-1:0] first_dly [LANES];
  logic [DLY_W-1:0] thr [LANES];
  logic [LANES-1:0] err, seen;
  logic mclk_q, in_sr;
  int faults, waits, xfers, odt_clks, tr_clks, sr_cnt, sr_seen, pend_cnt, lane;
  wire access = psel_i && penable_i;
  wire mclk_rise = mem_clock_i && !mclk_q;
  wire [31:0] d = req_i.wdata;
  // Odd transfers stall two cycles, so slow and prompt answers both occur.
  assign pready_o = access && (waits >= (xfers[0] ? 2 : 0));
  // Outside a completed transfer the data lines carry junk, which reset clears and negation keeps at zero.
  assign prdata_o = !pready_o ? junk : req_i.addr == OFS_LV_ERR ? {23'h0, err} :
    req_i.addr == OFS_SELF_REF ? self_ref : req_i.addr == OFS_FREQ ? freq : 32'h0;
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    assign err[g] = dly[g] >= thr[g];
  end
  initial for (int i = 0; i < LANES; i++) thr[i] = 9'h028 + 9'(11 * i);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {refresh, freq, self_ref, phy, term, junk} <= 192'h0;
      {faults, waits, xfers, odt_clks, tr_clks, sr_cnt, sr_seen, pend_cnt} <= 256'h0;
      {seen, in_sr, mclk_q} <= 11'h0;
    end else begin
      junk <= ~junk + 32'h1;
      mclk_q <= mem_clock_i;
      if (mclk_rise) begin
        odt_clks <= odt_clks + 1;
        tr_clks <= tr_clks + 1;
      end
      waits <= (access && !pready_o) ? waits + 1 : 0;
      sr_cnt <= (self_ref[1:0] != 2'h0) ? sr_cnt + 1 : 0;
      if (sr_cnt == 20) begin
        self_ref[1:0] <= 2'h0;
        in_sr <= self_ref[BIT_SR_ENTER];
        sr_seen <= sr_seen + int'(self_ref[BIT_SR_ENTER]);
      end
      pend_cnt <= freq[BIT_FREQ_PEND] ? pend_cnt + 1 : 0;
      if (pend_cnt == 30) freq[BIT_FREQ_PEND] <= 1'b0;
      if (pready_o) xfers <= xfers + 1;
      if (pready_o && req_i.write) begin
        case (req_i.addr)
          OFS_REFRESH: refresh <= d;
          OFS_SELF_REF: self_ref <= d;
          OFS_ODT_TERM: begin
            term <= d;
            if (odt_clks < 10) faults <= faults + 1;
          end
          OFS_FREQ: begin
            freq <= d;
            freq[BIT_FREQ_PEND] <= (d[BIT_FREQ_VALID] && !freq[BIT_FREQ_VALID]) ||
              freq[BIT_FREQ_PEND];
            if (in_sr && !phy[BIT_COMP_DIS]) faults <= faults + 1;
          end
          OFS_PHY_TRAIN: begin
            phy <= d;
            if (d[BIT_TRAIN_EN] && !phy[BIT_TRAIN_EN]) begin
              tr_clks <= 0;
              if (d[BIT_TRAIN_MODE] !== TRAIN_MODE_SW || !refresh[BIT_AUTO_REF_DIS] ||
                  freq[FLD_ZQ +: 2] != ZQ_OFF) faults <= faults + 1;
            end
            if (!d[BIT_TRAIN_EN] && phy[BIT_TRAIN_EN] && tr_clks < 32) begin
              faults <= faults + 1;
            end
            if (d[BIT_ODT_EN] != phy[BIT_ODT_EN]) odt_clks <= 0;
            if (d[BIT_ODT_EN] && !phy[BIT_ODT_EN]) seen <= '0;
            if (!d[BIT_COMP_DIS] && phy[BIT_COMP_DIS] && freq[BIT_FREQ_PEND]) begin
              faults <= faults + 1;
            end
          end
          default: begin
            if (req_i.addr >= OFS_LANE_DLY && req_i.addr < OFS_LANE_DLY + 12'h024) begin
              lane = int'(req_i.addr - OFS_LANE_DLY) / 4;
              dly[lane] <= d[DLY_W-1:0];
              if (!seen[lane]) first_dly[lane] <= d[DLY_W-1:0];
              seen[lane] <= 1'b1;
              if (!phy[BIT_ODT_EN] || odt_clks < 10) faults <= faults + 1;
            end
          end
        endcase
      end
    end
  end
endmodule : ddr3_wl_dev_model

// ---- ddr3_wl_host_test.sv ----
/*
  Self-checking bench for the write-leveling host: software APB tasks, the device
  model on the far side and a free 48 ns memory clock.
  Assumes the host package and the device model are compiled first.
*/
`timescale 1ns/10ps
module ddr3_wl_host_test;
  import ddr3_wl_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic mclk = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, dev_prdata, raw_q;
  logic pready, pslverr, dev_psel, dev_penable, dev_pready;
  dev_req_s dev_req;
  logic [DLY_W-1:0] prev [LANES];
  int errors, samples_checked;

  ddr3_wl_host #(.MAX_ITER(64)) dut (.core_clk_i(clk), .resetn_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .mem_clock_i(mclk),
    .dev_psel_o(dev_psel), .dev_penable_o(dev_penable), .dev_req_o(dev_req),
    .dev_prdata_i(dev_prdata), .dev_pready_i(dev_pready));
  ddr3_wl_dev_model dev (.core_clk_i(clk), .resetn_i(rst_n), .mem_clock_i(mclk),
    .psel_i(dev_psel), .penable_i(dev_penable), .req_i(dev_req), .prdata_o(dev_prdata),
    .pready_o(dev_pready));

  initial forever #2.5 clk = ~clk;
  initial begin
    #7;
    forever #24 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    check(e, 1'b0, "write error flag");
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  // Orders a sequence, then waits for the go bits to drain and busy to fall.
  task automatic run(input logic [31:0] ctrl);
    logic [31:0] q;
    wr(SW_CTRL, ctrl);
    q = 32'hf;
    for (int n = 0; n < 30000 && q[3:0] !== 4'h0; n++) rd(SW_CTRL, q);
    q = 32'h1;
    for (int n = 0; n < 30000 && q[0] !== 1'b0; n++) rd(SW_STATUS, q);
    check(q[2:0], 3'b010, "status after sequence");
  endtask : run

  task automatic t_regs();
    logic [31:0] q;
    logic e;
    rd(SW_STATUS, q);
    check(q, 32'h0, "status after reset");
    apb(1'b0, 12'hffc, 32'h0, q, e);
    check(e, 1'b1, "unmapped read flag");
    check(q, 32'h0, "unmapped read data");
    apb(1'b1, 12'hffc, 32'hffff_ffff, q, e);
    check(e, 1'b1, "unmapped write flag");
    wr(SW_FREQ, 32'h0215_0005);
    rd(SW_FREQ, q);
    check(q, 32'h0215_0005, "frequency register");
    $display("test registers done");
  endtask : t_regs

  task automatic t_level(input logic [31:0] cfg, input logic pass2,
                         input logic [DLY_W-1:0] seed);
    logic [31:0] q;
    logic [DLY_W-1:0] s;
    run(cfg | 32'h1);
    for (int i = 0; i < LANES; i++) begin
      s = pass2 ? DLY_W'((32'(prev[i]) * 533) / 400) : seed;
      check(dev.first_dly[i], s, "lane seed");
      rd(SW_LANE_BASE + 12'(4 * i), q);
      prev[i] = (dev.thr[i] > s) ? dev.thr[i] - 9'h001 : dev.thr[i];
      check(q, prev[i], "lane final delay");
    end
    check(dev.phy[BIT_ODT_EN], 1'b0, "odt enable left on");
    check(dev.phy[FLD_DIMM +: 2], cfg[CTL_DIMM +: 2], "dimm select");
    check(dev.phy[FLD_ODT +: 4], cfg[CTL_ODT +: 4], "odt pattern");
    check(dev.faults, 0, "device ordering faults");
    $display("test leveling done");
  endtask : t_level

  task automatic t_freq();
    run(32'h2);
    check(dev.freq[FLD_FREQ_CODE +: 3], 3'h5, "new frequency code");
    check(dev.freq[BIT_FREQ_VALID], 1'b1, "frequency valid");
    check(dev.phy[BIT_COMP_DIS], 1'b0, "compensation re-enabled");
    check(dev.sr_seen, 1, "self refresh entries");
    check(dev.in_sr, 1'b0, "self refresh left");
    check(dev.faults, 0, "device ordering faults");
    $display("test frequency change done");
  endtask : t_freq

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_level(32'h0009_2080, 1'b0, SEED_UDIMM);
    check(dev.term[FLD_TERM +: 3], TERM_NORMAL, "termination restored");
    t_freq();
    t_level(32'h0005_1040, 1'b1, SEED_UDIMM);
    t_level(32'h0003_0010, 1'b0, SEED_RDIMM_A);
    t_level(32'h0003_0030, 1'b0, SEED_RDIMM_B);
    run(32'h0020_0004);
    check(dev.refresh[BIT_AUTO_REF_DIS], 1'b0, "auto refresh restored");
    check(dev.freq[FLD_ZQ +: 2], 2'h2, "normal zq interval");
    wr(SW_RAW_CMD, 32'h8000_0094);
    run(32'h8);
    rd(SW_RAW_DATA, raw_q);
    check(raw_q, 32'h0000_080d, "raw read");
    $display("test finish done");
    close_out();
  end
endmodule : ddr3_wl_host_test
